// >>> hdl/adcsr_pkg.sv
/*
  Constants for the converter status and mode register block: register
  select codes, field positions, reset values and serial word lengths.
  Assumes a single clock domain and no other shared definitions.
*/
// Overview of operation
// - An eight-bit read-only status register is read by a command selecting a read at code zero.
// - Status resets to 0x80 and is shifted out most significant bit first.
// - The active-low ready bit clears when a new result is written to the data register.
// - Ready sets after the data register is read and shortly before the data register updates.
// - Ready also sets on entering power-down or idle mode and while sync is held low.
// - The error bit updates with ready and flags a result clamped to all zeros or all ones.
// - With reference detect on, a low reference sets the missing flag and clamps results to ones.
// - With parity enabled, the parity bit shows odd parity of the data register.
// - Status bit three always reads zero.
// - The channel tag reports the channel of the held result, not the one being converted.
// - A 24-bit read/write mode register resets to 0x080060.
// - Every mode write resets modulator and filter and sets the ready bit.
// - Mode bit 23 goes first; 23:21 mode, 20 append status, 19:18 clock source, 17:16 zero.
// - Mode low bits: 15 third-order filter, 14 zero, 13 parity, 12 divide, 11 single, 10 notch, 9:0 rate.
// - End of conversion is also shown on the shared serial-output/ready pin.
package adcsr_pkg;
  localparam logic [2:0]  ADCSR_SEL_STATUS   = 3'h0;
  localparam logic [2:0]  ADCSR_SEL_MODE     = 3'h1;
  localparam logic [2:0]  ADCSR_SEL_DATA     = 3'h3;
  localparam logic [7:0]  ADCSR_STATUS_RESET = 8'h80;
  localparam logic [23:0] ADCSR_MODE_RESET   = 24'h080060;
  localparam logic [23:0] ADCSR_MODE_WMASK   = 24'hFCBFFF; // bits 17,16,14 fixed zero
  localparam int ADCSR_SR_RDY    = 7;
  localparam int ADCSR_SR_ERR    = 6;
  localparam int ADCSR_SR_REFERENCE_MISSING_FLAG  = 5;
  localparam int ADCSR_SR_PAR    = 4;
  localparam int ADCSR_MR_MODE_LO = 21;
  localparam int ADCSR_MR_APPEND  = 20;
  localparam int ADCSR_MR_PARITY  = 13;
  localparam logic [2:0]  ADCSR_MODE_IDLE    = 3'h4;
  localparam logic [2:0]  ADCSR_MODE_PDOWN   = 3'h3;
  localparam logic [5:0]  ADCSR_STATUS_BITS  = 6'h08;
  localparam logic [5:0]  ADCSR_MODE_BITS    = 6'h18;
  localparam logic [5:0]  ADCSR_DATA_BITS    = 6'h18;
  localparam logic [5:0]  ADCSR_DATA_ST_BITS = 6'h20;
endpackage

// >>> hdl/adcsr_shifter.sv
/*
  Serial shifter: loads a word left-justified in 32 bits and shifts it out
  msb first, one bit per shift pulse. Assumes shift pulses come from the
  host's serial clock edges, already synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsr_shifter
  import adcsr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        load_i,
  input  wire logic [31:0] word_i,
  input  wire logic [5:0]  len_i,
  input  wire logic        shift_i,
  output logic             bit_o,
  output logic             busy_o,
  output logic             last_o
);
  logic [31:0] sh_q;
  logic [5:0]  cnt_q;

  // Msb first; word left-justified so bit 31 is always next out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh_q  <= 32'h0000_0000;
      cnt_q <= 6'h00;
    end
    else if (load_i)
    begin
      sh_q  <= word_i;
      cnt_q <= len_i;
    end
    else if (shift_i && cnt_q != 6'h00)
    begin
      sh_q  <= {sh_q[30:0], 1'b0};
      cnt_q <= cnt_q - 6'h01;
    end
  end

  assign bit_o  = sh_q[31];
  assign busy_o = (cnt_q != 6'h00);
  assign last_o = (cnt_q == 6'h01) && shift_i;
endmodule
`default_nettype wire

// >>> hdl/adcsr_top.sv
/*
  Status and mode registers of a 24-bit converter, read and written over
  the serial port after the communications register has been decoded.
  Assumes an outside decoder presents the register select, a read or
  write start, write data and shift pulses, all synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsr_top
  import adcsr_pkg::*;
#(
  parameter int SETTLE_WARN = 4 // Not used; ready rises ahead of a new result on result_pending_i
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  reg_sel_i,
  input  wire logic        rd_start_i,
  input  wire logic        wr_mode_i,
  input  wire logic [23:0] wr_data_i,
  input  wire logic        shift_i,
  input  wire logic        result_pending_i,
  input  wire logic        result_valid_i,
  input  wire logic [23:0] result_raw_i,
  input  wire logic        result_over_i,
  input  wire logic [2:0]  result_channel_i,
  input  wire logic        reference_detect_enable_i,
  input  wire logic        ref_low_i,
  input  wire logic        sync_n_i,
  output logic [7:0]       converter_status_o,
  output logic [23:0]      operating_mode_o,
  output logic [23:0]      data_o,
  output logic             mod_reset_o,
  output logic             dout_rdy_o,
  output logic             xfer_busy_o
);
  typedef enum logic [2:0]
  {
    ADCSR_IDLE_S = 3'b001,
    ADCSR_SEND_S = 3'b010,
    ADCSR_DONE_S = 3'b100
  } adcsr_state_type;

  adcsr_state_type state_q;
  adcsr_state_type state_d;

  logic        rdy_n_q;
  logic        err_q;
  logic        reference_missing_flag_q;
  logic [2:0]  chan_q;
  logic [23:0] data_q;
  logic [23:0] mode_q;
  logic        mod_reset_q;
  logic        dout_q;
  logic        busy_q;
  logic        data_read_q;
  logic [7:0]  status_w;
  logic        sh_bit;
  logic        sh_busy;
  logic        sh_last;
  logic        load;
  logic [31:0] load_word;
  logic [5:0]  load_len;
  logic        mode_sleep;
  logic [23:0] clamped;
  logic        clamp_err;

  // Odd parity over the held result
  function automatic logic odd_parity(input logic [23:0] v);
    odd_parity = ^v;
  endfunction

  // Clamp results: missing reference forces all ones
  always_comb
  begin
    clamped   = result_raw_i;
    clamp_err = result_over_i;
    if (reference_detect_enable_i && ref_low_i)
    begin
      clamped   = 24'hFFFFFF;
      clamp_err = 1'b1;
    end
    else if (result_over_i)
    begin
      clamped = result_raw_i; // Converter already saturated the code
    end
  end

  assign mode_sleep = (mode_q[23:21] == ADCSR_MODE_IDLE) ||
                      (mode_q[23:21] == ADCSR_MODE_PDOWN);

  // Status image; bit three is tied low
  always_comb
  begin
    status_w                = 8'h00;
    status_w[ADCSR_SR_RDY]  = rdy_n_q;
    status_w[ADCSR_SR_ERR]  = err_q;
    status_w[ADCSR_SR_REFERENCE_MISSING_FLAG] = reference_missing_flag_q;
    status_w[ADCSR_SR_PAR]  = mode_q[ADCSR_MR_PARITY] && odd_parity(data_q);
    status_w[2:0]           = chan_q;
  end

  // Data register, channel tag and error latch on each new result outside idle and power-down
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_q <= 24'h000000;
      chan_q <= 3'h0;
      err_q  <= 1'b0;
    end
    else if (result_valid_i && !mode_sleep)
    begin
      data_q <= clamped;
      chan_q <= result_channel_i;
      err_q  <= clamp_err;
    end
  end

  // Reference flag follows the detector while enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reference_missing_flag_q <= 1'b0;
    else
      reference_missing_flag_q <= reference_detect_enable_i && ref_low_i;
  end

  // Ready bit: setting causes outrank the clear from a new result
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdy_n_q <= ADCSR_STATUS_RESET[ADCSR_SR_RDY];
    else if (wr_mode_i)
      rdy_n_q <= 1'b1;
    else if (mode_sleep || !sync_n_i)
      rdy_n_q <= 1'b1;
    else if (result_pending_i)
      rdy_n_q <= 1'b1;
    else if (data_read_q)
      rdy_n_q <= 1'b1;
    else if (result_valid_i)
      rdy_n_q <= 1'b0;
  end

  // Mode register; fixed-zero bits are masked on write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q      <= ADCSR_MODE_RESET;
      mod_reset_q <= 1'b0;
    end
    else
    begin
      mod_reset_q <= wr_mode_i;
      if (wr_mode_i)
        mode_q <= wr_data_i & ADCSR_MODE_WMASK;
    end
  end

  // Pick the word to shift for a read
  always_comb
  begin
    load      = 1'b0;
    load_word = 32'h0000_0000;
    load_len  = 6'h00;
    if (rd_start_i && state_q == ADCSR_IDLE_S)
    begin
      load = 1'b1;
      unique case (reg_sel_i)
        ADCSR_SEL_STATUS:
        begin
          load_word = {status_w, 24'h000000};
          load_len  = ADCSR_STATUS_BITS;
        end
        ADCSR_SEL_MODE:
        begin
          load_word = {mode_q, 8'h00};
          load_len  = ADCSR_MODE_BITS;
        end
        ADCSR_SEL_DATA:
        begin
          if (mode_q[ADCSR_MR_APPEND])
          begin
            load_word = {data_q, status_w};
            load_len  = ADCSR_DATA_ST_BITS;
          end
          else
          begin
            load_word = {data_q, 8'h00};
            load_len  = ADCSR_DATA_BITS;
          end
        end
        default:
        begin
          load = 1'b0; // Other registers live elsewhere
        end
      endcase
    end
  end

  adcsr_shifter u_shift
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (load),
    .word_i (load_word),
    .len_i  (load_len),
    .shift_i(shift_i),
    .bit_o  (sh_bit),
    .busy_o (sh_busy),
    .last_o (sh_last)
  );

  // Read sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ADCSR_IDLE_S: if (load) state_d = ADCSR_SEND_S;
      ADCSR_SEND_S: if (sh_last) state_d = ADCSR_DONE_S;
      ADCSR_DONE_S: state_d = ADCSR_IDLE_S;
    endcase
  end

  logic is_data_read_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q        <= ADCSR_IDLE_S;
      is_data_read_q <= 1'b0;
      data_read_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (load)
        is_data_read_q <= (reg_sel_i == ADCSR_SEL_DATA);
      data_read_q <= sh_last && is_data_read_q; // One pulse at the end of a data register read
    end
  end

  // Shared pin: data bit while sending, otherwise the ready level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dout_q <= 1'b1;
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= sh_busy;
      dout_q <= sh_busy ? sh_bit : rdy_n_q;
    end
  end

  // Registered copies drive every output
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      converter_status_o <= ADCSR_STATUS_RESET;
      operating_mode_o   <= ADCSR_MODE_RESET;
      data_o             <= 24'h000000;
      mod_reset_o        <= 1'b0;
    end
    else
    begin
      converter_status_o <= status_w;
      operating_mode_o   <= mode_q;
      data_o             <= data_q;
      mod_reset_o        <= mod_reset_q;
    end
  end

  assign dout_rdy_o  = dout_q;
  assign xfer_busy_o = busy_q;
endmodule
`default_nettype wire

// >>> tb/adcsr_sva.sv
/* Checker for the status and mode register block ports.
   Assumes one clock and a bind onto adcsr_top. */
`timescale 1ns/1ps
`default_nettype none
module adcsr_sva
  import adcsr_pkg::*;
#(
  parameter int SETTLE_WARN = 4
)
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [2:0]  reg_sel_i,
  input wire logic        rd_start_i,
  input wire logic        wr_mode_i,
  input wire logic [23:0] wr_data_i,
  input wire logic        result_pending_i,
  input wire logic        result_valid_i,
  input wire logic        result_over_i,
  input wire logic        sync_n_i,
  input wire logic [7:0]  converter_status_o,
  input wire logic [23:0] operating_mode_o,
  input wire logic        mod_reset_o,
  input wire logic        xfer_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write ends in a modulator reset pulse
  sequence s_wr_done;
    ##2 mod_reset_o;
  endsequence
  // Reset pulse, status image, mode field and read start checks
  a_wr_pulse: assert property (wr_mode_i |-> s_wr_done) else $error("no reset pulse");
  a_mode_load: assert property (wr_mode_i |-> ##2
    operating_mode_o == ($past(wr_data_i, 2) & ADCSR_MODE_WMASK)) else $error("mode");
  a_wr_ready: assert property (wr_mode_i |-> ##[1:3] converter_status_o[7])
    else $error("write left ready low");
  a_err_clamp: assert property (result_valid_i && result_over_i |-> ##[1:3]
    converter_status_o[6]) else $error("error bit");
  a_bit3_zero: assert property (converter_status_o[3] == 1'b0) else $error("bit3");
  a_fixed_zero: assert property (operating_mode_o[17:16] == 2'h0 && !operating_mode_o[14])
    else $error("fixed mode bits");
  a_sync_ready: assert property (!sync_n_i |-> ##[1:3] converter_status_o[7])
    else $error("sync ready");
  a_pend_ready: assert property (result_pending_i |-> ##[1:3] converter_status_o[7])
    else $error("pending ready");
  a_read_start: assert property (rd_start_i && !xfer_busy_o && reg_sel_i == ADCSR_SEL_STATUS
    |-> ##2 xfer_busy_o) else $error("read start");
endmodule
`default_nettype wire

// >>> tb/adcsr_host.sv
/* Host side of the serial port: starts reads and clocks bits out.
   Assumes the decoded command inputs of adcsr_top. */
`timescale 1ns/1ps
`default_nettype none
module adcsr_host (
  input  wire logic  clk_i,
  input  wire logic  dout_rdy_i,
  input  wire logic  busy_i,
  output logic [2:0] reg_sel_o,
  output logic       rd_start_o,
  output logic       shift_o
);
  initial {reg_sel_o, rd_start_o, shift_o} = 5'h00;
  // One read msb first; tmo flags a port that never answers
  task automatic rd(input logic [2:0] s, input int n, output logic [31:0] w, output bit tmo);
    int k;
    w = '0;
    k = 0;
    @(posedge clk_i);
    reg_sel_o <= s;
    rd_start_o <= 1'b1;
    @(posedge clk_i);
    rd_start_o <= 1'b0;
    do @(negedge clk_i); while (busy_i !== 1'b1 && ++k < 8);
    tmo = (busy_i !== 1'b1);
    // Caller picks 32 bits when status is appended
    if (!tmo) for (int i = 0; i < n; i++)
    begin
      @(negedge clk_i);
      w = {w[30:0], dout_rdy_i};
      @(posedge clk_i);
      shift_o <= 1'b1;
      @(posedge clk_i);
      shift_o <= 1'b0;
      @(posedge clk_i);
    end
    k = 0;
    do @(negedge clk_i); while (busy_i !== 1'b0 && ++k < 8);
    tmo = tmo | (busy_i !== 1'b0);
    @(posedge clk_i); // Idle cycle before the next read
  endtask
endmodule
`default_nettype wire

// >>> tb/adcsr_top_tb.sv
/* Testbench for adcsr_top with a host model on the serial side.
   Assumes the package and design files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module adcsr_top_tb
  import adcsr_pkg::*;
;
  logic clk_i, rst_i, wr_mode_i, result_pending_i, result_valid_i, result_over_i;
  logic reference_detect_enable_i, ref_low_i, sync_n_i, rd_start_i, shift_i;
  logic mod_reset_o, dout_rdy_o, xfer_busy_o;
  logic [2:0] reg_sel_i, result_channel_i;
  logic [7:0] converter_status_o;
  logic [23:0] wr_data_i, result_raw_i, operating_mode_o, data_o;
  logic [31:0] w;
  bit t;
  int error_cnt = 0, num_checks = 0;
  // Result rows: raw, clamp, channel, low reference, status
  logic [23:0] t_raw [4] = '{24'h000001, 24'h00000F, 24'h000003, 24'hFFFFFF};
  logic [2:0]  t_ch [4] = '{3'h5, 3'h1, 3'h2, 3'h7};
  logic        t_ov [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic        t_rl [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0]  t_st [4] = '{8'h15, 8'h61, 8'h02, 8'h47};
  adcsr_top uut (.clk_i, .rst_i, .reg_sel_i, .rd_start_i, .wr_mode_i, .wr_data_i, .shift_i,
    .result_pending_i, .result_valid_i, .result_raw_i, .result_over_i, .result_channel_i,
    .reference_detect_enable_i, .ref_low_i, .sync_n_i, .converter_status_o,
    .operating_mode_o, .data_o, .mod_reset_o, .dout_rdy_o, .xfer_busy_o);
  adcsr_host host (.clk_i, .dout_rdy_i(dout_rdy_o), .busy_i(xfer_busy_o),
    .reg_sel_o(reg_sel_i), .rd_start_o(rd_start_i), .shift_o(shift_i));
  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task give_verdict;
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ends at a falling edge so outputs have settled
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task wm(input logic [23:0] d);
    @(posedge clk_i);
    wr_data_i <= d;
    wr_mode_i <= 1'b1;
    @(posedge clk_i);
    wr_mode_i <= 1'b0;
    tick(3);
  endtask
  task res(input logic [23:0] r, input logic ov, input logic [2:0] ch, input logic rl);
    @(posedge clk_i);
    {result_raw_i, result_over_i, result_channel_i, ref_low_i} <= {r, ov, ch, rl};
    @(posedge clk_i);
    result_valid_i <= 1'b1;
    @(posedge clk_i);
    result_valid_i <= 1'b0;
    tick(3);
  endtask
  task rd(input logic [2:0] s, input int n);
    host.rd(s, n, w, t);
    if (t)
    begin
      error_cnt++;
      give_verdict;
    end
    tick(1);
  endtask
  initial
  begin
    {wr_mode_i, result_pending_i, result_valid_i, result_over_i, ref_low_i} = 5'h00;
    {wr_data_i, result_raw_i, result_channel_i} = '0;
    {reference_detect_enable_i, sync_n_i, rst_i} = 3'h7;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(converter_status_o, 32'h80);
    chk(operating_mode_o, 32'h080060);
    chk(dout_rdy_o, 32'h1);
    rd(ADCSR_SEL_STATUS, 8);
    chk(w, 32'h80);
    wm(24'h036060);
    chk(operating_mode_o, 32'h002060);
    chk(converter_status_o, 32'h80);
    for (int i = 0; i < 4; i++)
    begin
      res(t_raw[i], t_ov[i], t_ch[i], t_rl[i]);
      chk(converter_status_o, t_st[i]);
      chk(data_o, t_rl[i] ? 24'hFFFFFF : t_raw[i]);
    end
    @(posedge clk_i);
    result_pending_i <= 1'b1;
    @(posedge clk_i);
    result_pending_i <= 1'b0;
    tick(2);
    chk(converter_status_o[7], 32'h1);
    res(24'h000007, 1'b0, 3'h4, 1'b0);
    chk(converter_status_o, 32'h14);
    wm(24'h002060);
    chk(converter_status_o, 32'h94);
    @(posedge clk_i);
    sync_n_i <= 1'b0;
    tick(2);
    chk(converter_status_o[7], 32'h1);
    @(posedge clk_i);
    sync_n_i <= 1'b1;
    wm(24'h102060);
    res(24'h000001, 1'b0, 3'h5, 1'b0);
    chk(dout_rdy_o, 32'h0);
    rd(ADCSR_SEL_DATA, 32);
    chk(w, 32'h00000115);
    chk(converter_status_o, 32'h95);
    rd(ADCSR_SEL_MODE, 24);
    chk(w, 32'h102060);
    wm(24'h802060);
    res(24'h000055, 1'b0, 3'h3, 1'b0);
    chk(data_o, 32'h000001);
    wm(24'h602060);
    res(24'h000077, 1'b0, 3'h6, 1'b0);
    chk(data_o, 32'h000001);
    chk(converter_status_o[7], 32'h1);
    host.rd(3'h2, 8, w, t);
    chk(t, 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(converter_status_o, 32'h80);
    chk(operating_mode_o, 32'h080060);
    give_verdict;
  end
endmodule
bind adcsr_top adcsr_sva #(.SETTLE_WARN(SETTLE_WARN)) sva_i (.clk_i, .rst_i, .reg_sel_i,
  .rd_start_i, .wr_mode_i, .wr_data_i, .result_pending_i, .result_valid_i, .result_over_i,
  .sync_n_i, .converter_status_o, .operating_mode_o, .mod_reset_o, .xfer_busy_o);
`default_nettype wire
